// file: core/conv_ctrl.sv
// converter power-up, trigger and sequential sampling control on apb
// assumes sample codes arrive from the analog front end on pclk
`timescale 1ns/1ps
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int BGR_CYC = BGR_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_trigger,
  input wire logic external_conversion_start,
  input wire logic [RESULT_W-1:0] sample_code_a,
  input wire logic [RESULT_W-1:0] sample_code_b,
  output logic [CHAN_W-1:0] channel_sel,
  output logic sample_hold,
  output logic [1:0] bandgap_reference_power_bits,
  output logic core_power_bit,
  output logic converter_irq
);
  localparam int BGW = $clog2(BGR_CYC + 1);
  localparam int PWW = $clog2(PWD_SETTLE_CYC + 1);
  localparam int PIPE_W = 2 * RESULT_W + CHAN_W + 1;
  // capture edge counts as the first stage of the result latency
  localparam int PIPE_DEPTH = RESULT_LAT_CYC;
  localparam logic [BGW-1:0] BGR_LAST = BGW'(BGR_CYC);
  localparam logic [PWW-1:0] PWD_LAST = PWW'(PWD_SETTLE_CYC);
  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(TRIG_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(SEQ_GAP_CYC - 1);

  typedef struct packed {
    seq_state_t st;
    logic [CNT_W-1:0] cnt;
    logic sh;
    logic [ACQ_W-1:0] acq;
    logic cont;
    logic pwm_en;
    logic ext_en;
    logic sw_start;
    logic [CHAN_W-1:0] chan;
    logic [1:0] bg;
    logic core;
    logic simultaneous_mode_select;
    logic [RESULT_W-1:0] res_a;
    logic [RESULT_W-1:0] res_b;
    logic [CHAN_W-1:0] res_chan;
    logic res_dual;
    logic [15:0] res_count;
    logic [EVT_W-1:0] stat;
    logic [EVT_W-1:0] int_en;
    logic [BGW-1:0] bg_cnt;
    logic [PWW-1:0] pwd_cnt;
    logic ready_prev;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [INT_LAG_CYC-1:0] lag;
    logic [31:0] rdata;
    logic irq;
  } ctrl_t;

  ctrl_t r;
  ctrl_t next_r;

  logic bg_on;
  logic bg_ok;
  logic pwd_ok;
  logic ready;
  logic ext_edge;
  logic trig;
  logic accept;
  logic capture;
  logic wr;
  logic rd_setup;
  logic hit;
  logic [EVT_W-1:0] evt;
  logic [CNT_W-1:0] sh_load;
  logic [PIPE_W-1:0] pipe_in;
  logic pipe_valid;
  logic [PIPE_W-1:0] pipe_out;
  logic [RESULT_W-1:0] pick_a;
  logic [31:0] rd;

  // power sequencing status
  assign bg_on = &r.bg;
  assign bg_ok = bg_on && (r.bg_cnt == BGR_LAST); // RL1
  assign pwd_ok = r.core && (r.pwd_cnt == PWD_LAST); // RL3
  assign ready = bg_ok && pwd_ok; // RL2 RL4

  // only the second sync stage feeds the edge detector
  assign ext_edge = r.ext_sync[1] && !r.ext_prev;
  assign trig = (pwm_trigger && r.pwm_en) // RL8
    || (ext_edge && r.ext_en)
    || r.sw_start;
  assign accept = trig && ready && (r.st == S_IDLE);

  // sample/hold width is (1 + acq) converter clocks
  assign sh_load = CNT_W'((32'(r.acq) + 1) * CONV_DIV - 1); // RL12
  // last high cycle: the front end still holds the sampled code
  assign capture = (r.st == S_SAMPLE) && (r.cnt == '0); // RL11

  // sequential: one channel, bank picked by the top channel bit
  assign pick_a = (!r.simultaneous_mode_select && r.chan[CHAN_W-1]) ? sample_code_b
    : sample_code_a; // RL9
  assign pipe_in = {r.simultaneous_mode_select, r.chan, sample_code_b, pick_a}; // RL7

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    unique case (paddr)
      OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_CTRL_THREE, OFS_RESULT,
      OFS_STATUS, OFS_INT_EN, OFS_INT_CLR, OFS_LIVE, OFS_COUNT: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // read word assembled at the setup phase, held through access
  always_comb begin
    rd = WORD_ZERO;
    unique case (paddr)
      OFS_CTRL_ONE: begin
        rd[ACQ_LSB +: ACQ_W] = r.acq;
        rd[CONT_BIT] = r.cont;
      end
      OFS_CTRL_TWO: begin
        rd[PWM_EN_BIT] = r.pwm_en;
        rd[EXT_EN_BIT] = r.ext_en;
        rd[CHAN_LSB +: CHAN_W] = r.chan;
      end
      OFS_CTRL_THREE: begin
        rd[BG_HI_BIT] = r.bg[1];
        rd[BG_LO_BIT] = r.bg[0];
        rd[CORE_BIT] = r.core;
        rd[SIMULTANEOUS_MODE_SELECT_BIT] = r.simultaneous_mode_select;
      end
      OFS_RESULT: begin
        rd[RES_A_LSB +: RESULT_W] = r.res_a;
        rd[RES_CHAN_LSB +: CHAN_W] = r.res_chan;
        rd[RES_B_LSB +: RESULT_W] = r.res_b;
        rd[RES_DUAL_BIT] = r.res_dual;
      end
      OFS_STATUS: begin
        rd[EVT_W-1:0] = r.stat;
      end
      OFS_INT_EN: begin
        rd[EVT_W-1:0] = r.int_en;
      end
      OFS_LIVE: begin
        rd[LIVE_BUSY_BIT] = r.st != S_IDLE;
        rd[LIVE_READY_BIT] = ready;
        rd[LIVE_BGR_OK_BIT] = bg_ok;
        rd[LIVE_SH_BIT] = r.sh;
      end
      OFS_COUNT: begin
        rd[15:0] = r.res_count;
      end
      default: begin
        rd = WORD_ZERO;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    evt = '0;

    // external start pin: two flops before any use
    next_r.ext_sync = {r.ext_sync[0], external_conversion_start};
    next_r.ext_prev = r.ext_sync[1];
    next_r.sw_start = 1'b0;

    // reference settling timer restarts whenever a reference bit drops
    if (!bg_on) begin
      next_r.bg_cnt = '0;
    end else if (!bg_ok) begin
      next_r.bg_cnt = r.bg_cnt + 1'b1; // RL1 RL4
    end
    // core settling only counts once the core bit is on
    if (!r.core) begin
      next_r.pwd_cnt = '0;
    end else if (!pwd_ok) begin
      next_r.pwd_cnt = r.pwd_cnt + 1'b1; // RL3
    end
    next_r.ready_prev = ready;
    evt[EVT_READY] = ready && !r.ready_prev;

    // sampling sequencer
    unique case (r.st)
      S_IDLE: begin
        if (accept) begin
          next_r.st = S_DELAY; // RL13
          next_r.cnt = DELAY_LOAD;
        end
      end
      S_DELAY: begin
        if (r.cnt == '0) begin
          next_r.st = S_SAMPLE;
          next_r.cnt = sh_load;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      S_SAMPLE: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 1'b1;
        end else if (r.cont && ready) begin
          // one converter clock gap keeps results (2 + acq) apart
          next_r.st = S_GAP; // RL15
          next_r.cnt = GAP_LOAD;
        end else begin
          next_r.st = S_IDLE;
        end
      end
      S_GAP: begin
        if (r.cnt == '0) begin
          next_r.st = S_SAMPLE; // RL9
          next_r.cnt = sh_load;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
    endcase
    next_r.sh = next_r.st == S_SAMPLE;

    // triggers while busy or unpowered are dropped and flagged
    evt[EVT_LOST] = trig && !accept;

    // result register loads 4 converter clocks after the pulse ends
    if (pipe_valid) begin
      next_r.res_a = pipe_out[RESULT_W-1:0]; // RL14 RL6
      next_r.res_b = pipe_out[2*RESULT_W-1:RESULT_W];
      next_r.res_chan = pipe_out[2*RESULT_W +: CHAN_W];
      next_r.res_dual = pipe_out[PIPE_W-1];
      next_r.res_count = r.res_count + 1'b1;
    end
    // the flag trails the result update by a few system clocks
    next_r.lag = {r.lag[INT_LAG_CYC-2:0], pipe_valid};
    evt[EVT_DONE] = r.lag[INT_LAG_CYC-1]; // RL10

    // register writes take effect in the access phase
    if (wr) begin
      unique case (paddr)
        OFS_CTRL_ONE: begin
          next_r.acq = pwdata[ACQ_LSB +: ACQ_W]; // RL12
          next_r.cont = pwdata[CONT_BIT];
        end
        OFS_CTRL_TWO: begin
          next_r.pwm_en = pwdata[PWM_EN_BIT];
          next_r.ext_en = pwdata[EXT_EN_BIT];
          next_r.sw_start = pwdata[SW_START_BIT]; // RL8
          next_r.chan = pwdata[CHAN_LSB +: CHAN_W]; // RL5
        end
        OFS_CTRL_THREE: begin
          next_r.bg = {pwdata[BG_HI_BIT], pwdata[BG_LO_BIT]}; // RL4
          next_r.core = pwdata[CORE_BIT]; // RL2
          next_r.simultaneous_mode_select = pwdata[SIMULTANEOUS_MODE_SELECT_BIT]; // RL7
        end
        OFS_INT_EN: begin
          next_r.int_en = pwdata[EVT_W-1:0];
        end
        OFS_INT_CLR: begin
          next_r.stat = r.stat & ~pwdata[EVT_W-1:0];
        end
        OFS_RESULT, OFS_STATUS, OFS_LIVE, OFS_COUNT: begin
          // read-only words, writes dropped without an error
        end
        default: begin
          next_r.rdata = r.rdata;
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    next_r.stat = next_r.stat | evt;
    // irq from next state, so it lines up with the status bit
    next_r.irq = |(next_r.stat & next_r.int_en);

    if (rd_setup) begin
      next_r.rdata = rd;
    end
  end

  // asynchronous reset leaves every power bit off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{
        st: S_IDLE,
        acq: ACQ_RST,
        chan: CHAN_RST,
        bg: BG_RST, // RL16
        stat: EVT_RST,
        int_en: EVT_RST,
        rdata: WORD_ZERO,
        default: '0
      };
    end else begin
      r <= next_r;
    end
  end

  // result register loads DEPTH edges after the capture edge
  conv_pipe #(
    .W(PIPE_W),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(capture), // RL11
    .in_data(pipe_in),
    .out_valid(pipe_valid),
    .out_data(pipe_out)
  );

  // zero wait states; only unmapped addresses report an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = r.rdata;
  assign channel_sel = r.chan;
  assign sample_hold = r.sh;
  assign bandgap_reference_power_bits = r.bg;
  assign core_power_bit = r.core;
  assign converter_irq = r.irq;
endmodule : conv_ctrl

// file: core/conv_ctrl_pkg.sv
// constants, field layout and state codes of the converter control block
// assumes one system clock at SYS_CLK_HZ and an apb master with 32-bit data
// Notes on behaviour
// [RL1] software turns both reference bits on before the core bit and allows 5 ms for the reference to settle.
// [RL2] software turns the core power bit on before it starts any conversion.
// [RL3] after the core bit goes on, software waits at least 20 us (typically 50 us, up to 1 ms) before converting.
// [RL4] all three power bits may be written at once, and then the first conversion waits the full reference settling time.
// [RL5] sixteen channels are selectable by software, taken one at a time or as a pair.
// [RL6] results are 12 bits wide and come out of a four-stage conversion pipeline.
// [RL7] the mode select bit picks sequential sampling at 0 and paired sampling at 1.
// [RL8] a conversion starts on a pwm event, a software start or the external start pin.
// [RL9] in sequential mode each sample/hold pulse converts the selected channel, optionally running on continuously.
// [RL10] the interrupt flag is raised a few system clocks after the result register updates, never before.
// [RL11] the selected channel is sampled at each falling edge of the sample/hold pulse.
// [RL12] the sample/hold pulse lasts one plus the 4-bit acquisition field converter clocks, 1 to 16.
// [RL13] sampling begins 2.5 converter clock periods after the trigger.
// [RL14] the first result lands in the result register 4 converter clocks after its sample/hold pulse ends.
// [RL15] later results follow two plus the acquisition field converter clocks after the one before.
// [RL16] after reset the reference and core power bits are cleared, so the converter starts powered down.
package conv_ctrl_pkg;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int CONV_CLK_HZ = 20_000_000;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  // trigger delay is counted in half converter periods
  localparam int TRIG_DELAY_HALF = 5;
  localparam int TRIG_DELAY_CYC = TRIG_DELAY_HALF * CONV_DIV / 2;
  localparam int RESULT_LAT_CLK = 4;
  localparam int RESULT_LAT_CYC = RESULT_LAT_CLK * CONV_DIV;
  localparam int SEQ_GAP_CLK = 1;
  localparam int SEQ_GAP_CYC = SEQ_GAP_CLK * CONV_DIV;
  localparam int PIPE_STAGES = 4;
  localparam int INT_LAG_CYC = 2;
  localparam int BGR_SETTLE_MS = 5;
  localparam int BGR_SETTLE_CYC = (BGR_SETTLE_MS * SYS_CLK_HZ + 999) / 1000;
  localparam int PWD_SETTLE_US = 20;
  localparam int PWD_SETTLE_CYC =
    (PWD_SETTLE_US * SYS_CLK_HZ + 999_999) / 1_000_000;
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 4;
  localparam int ACQ_W = 4;
  localparam int CNT_W = 6;
  localparam int EVT_W = 3;
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_EN = 8'h14;
  localparam logic [7:0] OFS_INT_CLR = 8'h18;
  localparam logic [7:0] OFS_LIVE = 8'h1C;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  localparam int ACQ_LSB = 8;
  localparam int CONT_BIT = 4;
  localparam int PWM_EN_BIT = 0;
  localparam int EXT_EN_BIT = 1;
  localparam int SW_START_BIT = 2;
  localparam int CHAN_LSB = 8;
  localparam int BG_HI_BIT = 7;
  localparam int BG_LO_BIT = 6;
  localparam int CORE_BIT = 5;
  localparam int SIMULTANEOUS_MODE_SELECT_BIT = 0;
  localparam int RES_A_LSB = 0;
  localparam int RES_B_LSB = 16;
  localparam int RES_DUAL_BIT = 31;
  localparam int RES_CHAN_LSB = 12;
  localparam int EVT_DONE = 0;
  localparam int EVT_LOST = 1;
  localparam int EVT_READY = 2;
  localparam int LIVE_BUSY_BIT = 0;
  localparam int LIVE_READY_BIT = 1;
  localparam int LIVE_BGR_OK_BIT = 2;
  localparam int LIVE_SH_BIT = 3;
  localparam logic [ACQ_W-1:0] ACQ_RST = 4'h0;
  localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
  localparam logic [1:0] BG_RST = 2'h0;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    S_IDLE,
    S_DELAY,
    S_SAMPLE,
    S_GAP
  } seq_state_t;
endpackage : conv_ctrl_pkg

// file: core/conv_pipe.sv
// delay line standing for the multi-stage conversion core
// assumes in_valid is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module conv_pipe #(
  parameter int W = 25,
  parameter int DEPTH = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0] v;
    logic [DEPTH-1:0][W-1:0] d;
  } pipe_t;

  pipe_t r;
  pipe_t next_r;

  always_comb begin
    next_r = r;
    next_r.v[0] = in_valid;
    next_r.d[0] = in_data;
    for (int i = 1; i < DEPTH; i++) begin
      next_r.v[i] = r.v[i-1];
      next_r.d[i] = r.d[i-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign out_valid = r.v[DEPTH-1];
  assign out_data = r.d[DEPTH-1];
endmodule : conv_pipe

// file: tb/conv_ctrl_assertions.sv
// port checker for the converter control block
// assumes a bind onto conv_ctrl, one pclk domain
`timescale 1ns/1ps
module conv_ctrl_assertions
  import conv_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic sample_hold,
  input wire logic [1:0] bandgap_reference_power_bits,
  input wire logic core_power_bit,
  input wire logic converter_irq
);
  logic [5:0] hi_cnt;
  logic fresh;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 6'h00;
      fresh <= 1'b1;
    end else begin
      hi_cnt <= sample_hold ? hi_cnt + 6'h01 : 6'h00;
      fresh <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sh_start; $rose(sample_hold); endsequence
  sequence sh_end; $fell(sample_hold); endsequence
  a_power_reset: assert property (fresh |->
    bandgap_reference_power_bits == 2'h0 && !core_power_bit)
    else $error("power bits set after reset");
  a_sh_min_width: assert property (sh_start |-> sample_hold[*2])
    else $error("hold pulse shorter than one converter clock");
  a_sh_max_width: assert property (hi_cnt <= 6'h20)
    else $error("hold pulse longer than sixteen converter clocks");
  a_sh_whole_clocks: assert property (sh_end |->
    hi_cnt[0] == 1'b0 && hi_cnt != 6'h00)
    else $error("hold pulse not whole converter clocks");
  a_sh_needs_power: assert property (sh_start |->
    core_power_bit && bandgap_reference_power_bits == 2'h3)
    else $error("sampling while powered down");
  a_sh_gap_low: assert property (sh_end |-> !sample_hold[*2])
    else $error("next hold pulse too soon");
  a_irq_after_result: assert property (
    sh_end ##0 !converter_irq |=> !converter_irq[*8])
    else $error("interrupt before result update");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h20
    |-> pslverr)
    else $error("no error on unmapped address");
endmodule : conv_ctrl_assertions

// file: tb/front_end_model.sv
// trigger sources and analog front end facing the control block
// assumes tasks are entered just after a rising pclk edge
`timescale 1ns/1ps
module front_end_model
  import conv_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic [CHAN_W-1:0] channel_sel,
  input wire logic sample_hold,
  output logic pwm_trigger,
  output logic external_conversion_start,
  output logic [RESULT_W-1:0] sample_code_a,
  output logic [RESULT_W-1:0] sample_code_b
);
  // code flips outside the hold window, so a late sample shows
  assign sample_code_a = {12{!sample_hold}}
    ^ {4'ha, 5'h00, channel_sel[2:0]};
  assign sample_code_b = {12{!sample_hold}}
    ^ {4'h5, 5'h00, channel_sel[2:0]};
  initial begin
    pwm_trigger = 1'b0;
    external_conversion_start = 1'b0;
  end
  task pwm_pulse;
    pwm_trigger <= 1'b1;
    @(posedge pclk);
    pwm_trigger <= 1'b0;
  endtask : pwm_pulse
  task pin_pulse;
    external_conversion_start <= 1'b1;
    repeat (4) @(posedge pclk);
    external_conversion_start <= 1'b0;
  endtask : pin_pulse
endmodule : front_end_model

// file: tb/tb_adc_powerup_and_sequential_timing.sv
// top bench: apb register access and conversion timing checks
// assumes conv_ctrl with a short reference settle count
`timescale 1ns/1ps
module tb_adc_powerup_and_sequential_timing
  import conv_ctrl_pkg::*;
;
  // longer than the core settle, as the real reference time is
  localparam int BGR = 1000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pwm_trigger, external_conversion_start, sample_hold;
  logic core_power_bit, converter_irq, prev_sh, prev_irq;
  logic [RESULT_W-1:0] sample_code_a, sample_code_b;
  logic [CHAN_W-1:0] channel_sel;
  logic [1:0] bandgap_reference_power_bits;
  int fails, n_checks, cyc, n_fall, t_trig, t_rise, t_fall, t_fprev, t_irq;
  int acqs[3] = '{0, 3, 15};
  int i, k, base;
  conv_ctrl #(.BGR_CYC(BGR)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_trigger(pwm_trigger),
    .external_conversion_start(external_conversion_start),
    .sample_code_a(sample_code_a), .sample_code_b(sample_code_b),
    .channel_sel(channel_sel), .sample_hold(sample_hold),
    .bandgap_reference_power_bits(bandgap_reference_power_bits),
    .core_power_bit(core_power_bit), .converter_irq(converter_irq));
  front_end_model i_fe (.pclk(pclk), .channel_sel(channel_sel),
    .sample_hold(sample_hold), .pwm_trigger(pwm_trigger),
    .external_conversion_start(external_conversion_start),
    .sample_code_a(sample_code_a), .sample_code_b(sample_code_b));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_sh <= sample_hold;
    prev_irq <= converter_irq;
    if (pwm_trigger) t_trig <= cyc;
    if (sample_hold && !prev_sh) t_rise <= cyc;
    if (!sample_hold && prev_sh) begin
      t_fprev <= t_fall;
      t_fall <= cyc;
      n_fall <= n_fall + 1;
    end
    if (converter_irq && !prev_irq) t_irq <= cyc;
  end
  task final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("Error %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      fails++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, want);
  endtask : rdc
  task wait_irq(input logic lvl);
    int n;
    n = 0;
    while (converter_irq !== lvl && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      fails++;
      final_report();
    end
  endtask : wait_irq
  // one conversion from a chosen source, result checked against codes
  task conv(input int src, input logic [3:0] ch, input logic dual);
    logic [11:0] ca, cb;
    logic [31:0] c2;
    ca = {4'ha, 5'h00, ch[2:0]};
    cb = {4'h5, 5'h00, ch[2:0]};
    c2 = {20'h0_0000, ch, 8'h03};
    wr(OFS_CTRL_TWO, c2);
    wr(OFS_INT_CLR, 32'h0000_0007);
    if (src == 0) i_fe.pwm_pulse();
    else if (src == 1) i_fe.pin_pulse();
    else wr(OFS_CTRL_TWO, c2 | 32'h0000_0004);
    wait_irq(1'b1);
    apb(1'b0, OFS_RESULT, 32'h0000_0000);
    if (dual) chk(rd, {1'b1, 3'h0, cb, ch, ca});
    else chk(rd & 32'h0000_ffff, {16'h0000, ch, ch[3] ? cb : ca});
  endtask : conv
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {fails, n_checks, cyc, n_fall} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, bandgap_reference_power_bits, core_power_bit}, 0);
    rdc(OFS_CTRL_THREE, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    wr(OFS_STATUS, 32'hffff_ffff);
    rdc(OFS_STATUS, 32'h0000_0000);
    // powered down: trigger is lost, flag masked until enabled
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    i_fe.pwm_pulse();
    repeat (2) @(posedge pclk);
    rdc(OFS_STATUS, 32'h0000_0002);
    chk({31'h0, converter_irq}, 32'h0000_0000);
    wr(OFS_INT_EN, 32'h0000_0002);
    wait_irq(1'b1);
    wr(OFS_INT_CLR, 32'h0000_0002);
    wait_irq(1'b0);
    wr(OFS_CTRL_THREE, 32'h0000_00c0);
    repeat (BGR) @(posedge pclk);
    rdc(OFS_LIVE, 32'h0000_0004);
    wr(OFS_CTRL_THREE, 32'h0000_00e0);
    chk({29'h0, bandgap_reference_power_bits, core_power_bit}, 7);
    repeat (PWD_SETTLE_CYC + 4) @(posedge pclk);
    rdc(OFS_STATUS, 32'h0000_0004);
    rdc(OFS_LIVE, 32'h0000_0006);
    wr(OFS_INT_EN, 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      wr(OFS_CTRL_ONE, acqs[i] << 8);
      conv(0, acqs[i][3:0], 1'b0);
      chk(t_rise - t_trig, TRIG_DELAY_CYC + 1);
      chk(t_fall - t_rise, (1 + acqs[i]) * CONV_DIV);
      chk(t_irq - t_fall, RESULT_LAT_CYC + INT_LAG_CYC);
    end
    conv(1, 4'h2, 1'b0);
    for (i = 0; i < 16; i++) conv(2, i[3:0], 1'b0);
    wr(OFS_CTRL_THREE, 32'h0000_00e1);
    conv(0, 4'h3, 1'b1);
    wr(OFS_CTRL_THREE, 32'h0000_00e0);
    // continuous run, acquisition field 1
    wr(OFS_CTRL_ONE, 32'h0000_0110);
    base = n_fall;
    i_fe.pwm_pulse();
    k = 0;
    while (n_fall < base + 2 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 300) begin
      fails++;
      final_report();
    end
    wr(OFS_CTRL_ONE, 32'h0000_0000);
    chk(t_fall - t_fprev, (2 + 1) * CONV_DIV);
    repeat (40) @(posedge pclk);
    // all three power bits at once
    wr(OFS_CTRL_THREE, 32'h0000_0000);
    wr(OFS_CTRL_THREE, 32'h0000_00e0);
    wr(OFS_INT_CLR, 32'h0000_0007);
    rdc(OFS_STATUS, 32'h0000_0000);
    // core settled here, reference still settling
    repeat (PWD_SETTLE_CYC + 4) @(posedge pclk);
    rdc(OFS_STATUS, 32'h0000_0000);
    repeat (BGR - PWD_SETTLE_CYC) @(posedge pclk);
    rdc(OFS_STATUS, 32'h0000_0004);
    final_report();
  end
endmodule : tb_adc_powerup_and_sequential_timing
bind conv_ctrl conv_ctrl_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .sample_hold(sample_hold), .core_power_bit(core_power_bit),
  .bandgap_reference_power_bits(bandgap_reference_power_bits),
  .converter_irq(converter_irq));
